// ---- hw/ebs_cfg_mem.v ----
/*
 * Small register file holding one timing word per chip select.
 * Assumes a single clock; read data come out of a register.
 */
`timescale 1ns/10ps
`include "ebs_defines.vh"

module ebs_cfg_mem #(
  parameter NCS = 4,                   // Number of chip selects.
  parameter AW  = 2                    // Index width.
) (
  input  wire          clk_i,          // System clock.
  input  wire          nrst_i,         // Asynchronous reset, active low.
  input  wire          we_i,           // Write strobe.
  input  wire [AW-1:0] waddr_i,        // Write index.
  input  wire [15:0]   wdata_i,        // Write data.
  input  wire [AW-1:0] raddr_i,        // Read index.
  output reg  [15:0]   rdata_o         // Registered read data.
);
  reg [15:0] mem_r [0:NCS-1];          // Timing words.
  genvar g;

  // Each word resets to a defined value so a cycle after reset is sane.
  generate
    for (g = 0; g < NCS; g = g + 1) begin : g_word
      always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          mem_r[g] <= `EBS_TW_RESET;
        end else if (we_i && (waddr_i == g)) begin
          mem_r[g] <= wdata_i;
        end
      end
    end
  endgenerate

  // Registered read port.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= `EBS_TW_RESET;
    end else begin
      rdata_o <= mem_r[raddr_i];
    end
  end
endmodule // ebs_cfg_mem

// ---- hw/ebs_defines.vh ----
/*
 * Constants of the external bus cycle phase sequencer: phase codes,
 * field layout of the per chip-select timing word, register offsets.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef EBS_DEFINES_VH
`define EBS_DEFINES_VH

// Phase state codes.
`define EBS_ST_IDLE     3'h0
`define EBS_ST_AB       3'h1
`define EBS_ST_C        3'h2
`define EBS_ST_D        3'h3
`define EBS_ST_E        3'h4
`define EBS_ST_RDY      3'h5
`define EBS_ST_F        3'h6

// Timing word field positions (chip_select_timing_config).
`define EBS_F_AB_LSB    0
`define EBS_F_AB_MSB    0
`define EBS_F_WIN_LSB   1
`define EBS_F_WIN_MSB   2
`define EBS_F_C_LSB     3
`define EBS_F_C_MSB     4
`define EBS_F_D_BIT     5
`define EBS_F_E_LSB     6
`define EBS_F_E_MSB     10
`define EBS_F_F_LSB     11
`define EBS_F_F_MSB     12
`define EBS_F_RDYEN_BIT 13
`define EBS_F_RDYPOL_BIT 14
`define EBS_F_RDYASY_BIT 15
`define EBS_TW_W        16

// Register offsets: timing words at index 0..N-1, then control, status.
`define EBS_REG_CTRL    8'h0040
`define EBS_REG_STAT    8'h0041
`define EBS_REG_RDATA   8'h0042
`define EBS_TW_RESET    16'h0000

`endif

// ---- hw/ebs_sequencer.v ----
/*
 * External bus cycle phase sequencer: runs one bus cycle as phases
 * address setup, command delay, write setup/turnaround, access, hold.
 * Assumes pins are synchronous to clk_i and one register port master.
 */
// Implementation choices: the strobed register port and the address map.
// Functional notes
// - Five phases in fixed order per cycle.
// - Phase lengths from per chip-select timing word.
// - Address setup lasts one or two periods.
// - Window change adds zero to three setup periods.
// - Write setup/turnaround lasts zero or one period.
// - Hold and command delay zero to three periods.
// - Access one to thirty-two periods, ready extends.
// - Reference clock out mirrors system clock when enabled.
// - Read data captured at end-of-strobe edge.
// - Ready inactive waits, ready active ends cycle.
// - Ready polarity selectable, async adds sync stage.
`timescale 1ns/10ps
`include "ebs_defines.vh"

module ebs_sequencer #(
  parameter NCS = 4,                   // Number of chip selects.
  parameter CSW = 2,                   // Chip select index width.
  parameter DW  = 16                   // Data bus width.
) (
  input  wire           clk_i,         // System clock, 100 MHz.
  input  wire           nrst_i,        // Asynchronous reset, active low.
  input  wire [7:0]     reg_addr_i,    // Register word address.
  input  wire [15:0]    reg_wdata_i,   // Register write data.
  input  wire           reg_wr_i,      // Register write strobe.
  input  wire           reg_rd_i,      // Register read strobe.
  output reg  [15:0]    reg_rdata_o,   // Read data, one cycle later.
  input  wire           req_i,         // Start a bus cycle (level, taken when idle).
  input  wire           req_write_i,   // One for a write cycle.
  input  wire [CSW-1:0] req_cs_i,      // Chip select of the cycle.
  input  wire [DW-1:0]  req_wdata_i,   // Write data of the cycle.
  output reg            busy_o,        // Cycle running.
  output reg            done_o,        // One-cycle pulse at cycle end.
  output reg  [DW-1:0]  rd_data_o,     // Captured read data.
  input  wire           ready_i,       // External ready input.
  input  wire [DW-1:0]  bus_d_i,       // Data bus input.
  output reg  [DW-1:0]  bus_d_o,       // Data bus output.
  output reg            bus_d_oe_n_o,  // Data bus enable, low drives.
  output reg  [NCS-1:0] cs_n_o,        // Chip selects, active low.
  output reg            rd_n_o,        // Read strobe, active low.
  output reg            wr_n_o,        // Write strobe, active low.
  output reg  [2:0]     phase_o,       // Current phase code.
  output reg            ref_clk_en_o   // Bus reference clock driver on.
);
  reg  [2:0]     st_r;                 // Phase state.
  reg  [2:0]     st_nxt;
  reg  [5:0]     cnt_r;                // Cycles left in phase.
  reg  [5:0]     cnt_nxt;
  reg  [15:0]    tw_r;                 // Timing word of running cycle.
  reg  [CSW-1:0] cs_r;                 // Running chip select.
  reg  [CSW-1:0] last_cs_r;            // Previous window.
  reg            write_r;              // Running cycle is a write.
  reg            ctrl_clk_r;           // Reference clock enable bit.
  reg            rdy_s1_r;             // Async ready first stage.
  reg            rdy_s2_r;             // Async ready second stage.
  reg            first_r;              // No cycle run since reset.
  reg            fetch_r;              // Timing word read in flight.
  wire [15:0]    tw_rd;                // Timing word from memory.
  wire           mem_we;
  wire           rdy_act;
  wire           rdy_raw;
  wire           rdy_sel;

  // Table write hits when the address indexes a chip select word.
  assign mem_we = reg_wr_i && (reg_addr_i < NCS);

  ebs_cfg_mem #(.NCS(NCS), .AW(CSW)) u_mem (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .we_i    (mem_we),
    .waddr_i (reg_addr_i[CSW-1:0]),
    .wdata_i (reg_wdata_i),
    .raddr_i (req_cs_i),
    .rdata_o (tw_rd)
  );

  // Polarity select then choice of direct or synchronised ready.
  assign rdy_raw = ready_i ^ ~tw_r[`EBS_F_RDYPOL_BIT];
  assign rdy_sel = tw_r[`EBS_F_RDYASY_BIT] ? rdy_s2_r : rdy_raw;
  assign rdy_act = rdy_sel;

  // Length of a phase, loaded when it is entered.
  function [5:0] ph_len;
    input [2:0]  ph;
    input [15:0] tw;
    input        win;
    begin
      case (ph)
        `EBS_ST_AB: ph_len = {5'h00, tw[`EBS_F_AB_MSB:`EBS_F_AB_LSB]} + 6'h01 +
                             (win ? {4'h0, tw[`EBS_F_WIN_MSB:`EBS_F_WIN_LSB]}
                                  : 6'h00);
        `EBS_ST_C:  ph_len = {4'h0, tw[`EBS_F_C_MSB:`EBS_F_C_LSB]};
        `EBS_ST_D:  ph_len = {5'h00, tw[`EBS_F_D_BIT]};
        `EBS_ST_E:  ph_len = {1'b0, tw[`EBS_F_E_MSB:`EBS_F_E_LSB]} + 6'h01;
        `EBS_ST_F:  ph_len = {4'h0, tw[`EBS_F_F_MSB:`EBS_F_F_LSB]};
        default:    ph_len = 6'h00;
      endcase
    end
  endfunction

  // Next state walks the phases in order and skips empty ones. The
  // skip is done here in one step, so no idle cycle is spent on them.
  always @* begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      `EBS_ST_IDLE: begin
        if (fetch_r) begin
          st_nxt  = `EBS_ST_AB;
          cnt_nxt = ph_len(`EBS_ST_AB, tw_rd,
                           first_r || (req_cs_i != last_cs_r));
        end
      end
      `EBS_ST_AB, `EBS_ST_C, `EBS_ST_D: begin
        if (cnt_r > 6'h01) begin
          cnt_nxt = cnt_r - 6'h01;
        end else if (st_r != `EBS_ST_D && ph_len(st_r + 3'h1, tw_r, 1'b0) == 6'h00) begin
          st_nxt  = st_r + 3'h2;
          cnt_nxt = ph_len(st_r + 3'h2, tw_r, 1'b0);
          if (st_nxt == `EBS_ST_D && cnt_nxt == 6'h00) begin
            st_nxt  = `EBS_ST_E;
            cnt_nxt = ph_len(`EBS_ST_E, tw_r, 1'b0);
          end
        end else begin
          st_nxt  = st_r + 3'h1;
          cnt_nxt = ph_len(st_r + 3'h1, tw_r, 1'b0);
        end
      end
      `EBS_ST_E: begin
        if (cnt_r > 6'h01) begin
          cnt_nxt = cnt_r - 6'h01;
        end else if (tw_r[`EBS_F_RDYEN_BIT]) begin
          st_nxt  = `EBS_ST_RDY;
        end else begin
          st_nxt  = (tw_r[`EBS_F_F_MSB:`EBS_F_F_LSB] == 2'h0) ? `EBS_ST_IDLE
                                                              : `EBS_ST_F;
          cnt_nxt = ph_len(`EBS_ST_F, tw_r, 1'b0);
        end
      end
      `EBS_ST_RDY: begin
        if (rdy_act) begin
          st_nxt  = (tw_r[`EBS_F_F_MSB:`EBS_F_F_LSB] == 2'h0) ? `EBS_ST_IDLE
                                                              : `EBS_ST_F;
          cnt_nxt = ph_len(`EBS_ST_F, tw_r, 1'b0);
        end
      end
      `EBS_ST_F: begin
        if (cnt_r > 6'h01) begin
          cnt_nxt = cnt_r - 6'h01;
        end else begin
          st_nxt = `EBS_ST_IDLE;
        end
      end
      default: begin
        st_nxt  = `EBS_ST_IDLE;
        cnt_nxt = 6'h00;
      end
    endcase
  end

  // Sequencer state, cycle context and the ready synchroniser.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r      <= `EBS_ST_IDLE;
      cnt_r     <= 6'h00;
      tw_r      <= `EBS_TW_RESET;
      cs_r      <= {CSW{1'b0}};
      last_cs_r <= {CSW{1'b0}};
      write_r   <= 1'b0;
      first_r   <= 1'b1;
      fetch_r   <= 1'b0;
      rdy_s1_r  <= 1'b0;
      rdy_s2_r  <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      rdy_s1_r <= ready_i ^ ~tw_r[`EBS_F_RDYPOL_BIT];
      rdy_s2_r <= rdy_s1_r;
      // The timing word is fetched one cycle before the cycle starts.
      fetch_r  <= req_i && st_r == `EBS_ST_IDLE && !fetch_r;
      if (fetch_r) begin
        tw_r      <= tw_rd;
        cs_r      <= req_cs_i;
        last_cs_r <= req_cs_i;
        write_r   <= req_write_i;
        first_r   <= 1'b0;
      end
    end
  end

  // Pin and status outputs, all registered; selects, strobes, bus enable, busy and phase from the next state.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o       <= 1'b0;
      done_o       <= 1'b0;
      rd_data_o    <= {DW{1'b0}};
      bus_d_o      <= {DW{1'b0}};
      bus_d_oe_n_o <= 1'b1;
      cs_n_o       <= {NCS{1'b1}};
      rd_n_o       <= 1'b1;
      wr_n_o       <= 1'b1;
      phase_o      <= `EBS_ST_IDLE;
      ref_clk_en_o <= 1'b0;
    end else begin
      busy_o       <= st_nxt != `EBS_ST_IDLE;
      done_o       <= st_r != `EBS_ST_IDLE && st_nxt == `EBS_ST_IDLE;
      phase_o      <= st_nxt;
      ref_clk_en_o <= ctrl_clk_r;
      // On the fetch edge cs_r still holds the previous select, so the
      // request's select is used there to keep the first setup period right.
      cs_n_o       <= (st_nxt == `EBS_ST_IDLE) ? {NCS{1'b1}}
                      : ~({{(NCS-1){1'b0}}, 1'b1} << (fetch_r ? req_cs_i : cs_r));
      rd_n_o       <= !(!write_r && (st_nxt == `EBS_ST_E || st_nxt == `EBS_ST_RDY));
      wr_n_o       <= !(write_r && (st_nxt == `EBS_ST_E || st_nxt == `EBS_ST_RDY));
      bus_d_o      <= req_wdata_i;
      bus_d_oe_n_o <= !(write_r && st_nxt != `EBS_ST_IDLE && st_nxt != `EBS_ST_AB);
      // Latch read data on the edge that ends the strobe; address
      // changes after this edge cannot disturb the captured value.
      if (!write_r && (st_r == `EBS_ST_E || st_r == `EBS_ST_RDY) &&
          st_nxt != st_r) begin
        rd_data_o <= bus_d_i;
      end
    end
  end

  // Control register and read port.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_clk_r  <= 1'b0;
      reg_rdata_o <= 16'h0000;
    end else begin
      if (reg_wr_i && reg_addr_i == `EBS_REG_CTRL) begin
        ctrl_clk_r <= reg_wdata_i[0];
      end
      if (reg_rd_i) begin
        case (reg_addr_i)
          `EBS_REG_CTRL:  reg_rdata_o <= {15'h0000, ctrl_clk_r};
          `EBS_REG_STAT:  reg_rdata_o <= {12'h000, busy_o, st_r};
          `EBS_REG_RDATA: reg_rdata_o <= rd_data_o;
          default:        reg_rdata_o <= 16'h0000;
        endcase
      end else begin
        reg_rdata_o <= 16'h0000;
      end
    end
  end
endmodule // ebs_sequencer

// ---- verification/ebs_chk.sv ----
/* Port checker for the bus cycle phase sequencer.
   Assumes one clock domain and a bind from the testbench top file. */
`timescale 1ns/10ps
module ebs_chk #(
  parameter NCS = 4                 // Number of chip selects.
) (
  input logic           clk_i,      // System clock.
  input logic           nrst_i,     // Reset, active low.
  input logic           done_o,     // Cycle end pulse.
  input logic [2:0]     phase_o,    // Phase code.
  input logic [NCS-1:0] cs_n_o,     // Chip selects, active low.
  input logic           rd_n_o,     // Read strobe, active low.
  input logic           wr_n_o      // Write strobe, active low.
);
  // All checks share the system clock and are quiet during reset.
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_setup_next: assert property (phase_o == 3'h1 |=> phase_o inside {[3'h1:3'h4]})
    else $error("address setup left to a wrong phase");
  chk_cmd_next: assert property (phase_o == 3'h2 |=> phase_o inside {[3'h2:3'h4]})
    else $error("command delay left to a wrong phase");
  chk_turn_once: assert property (phase_o == 3'h3 |=> phase_o == 3'h4)
    else $error("write setup did not last one period");
  chk_access_next: assert property (phase_o == 3'h4 |=> phase_o != 3'h1 && phase_o != 3'h2)
    else $error("access phase left to a wrong phase");
  chk_hold_next: assert property (phase_o == 3'h6 |=> phase_o inside {3'h0, 3'h6})
    else $error("hold phase left to a wrong phase");
  chk_setup_max: assert property ((phase_o == 3'h1) [*5] |=> phase_o != 3'h1)
    else $error("address setup longer than five periods");
  chk_cmd_max: assert property ((phase_o == 3'h2) [*3] |=> phase_o != 3'h2)
    else $error("command delay longer than three periods");
  chk_strobe_access: assert property (!(rd_n_o && wr_n_o) |-> phase_o inside {3'h4, 3'h5} && (rd_n_o || wr_n_o))
    else $error("strobe outside the access phase");
  chk_one_select: assert property (phase_o != 3'h0 |-> $onehot(~cs_n_o))
    else $error("not exactly one chip select active");
  chk_done_end: assert property (done_o |-> phase_o == 3'h0 && $past(phase_o) inside {[3'h4:3'h6]})
    else $error("cycle end not after access or hold");
  // Main scenarios: a ready wait, a stretched setup, a finished cycle.
  cov_wait: cover property (phase_o == 3'h5);
  cov_long_setup: cover property ((phase_o == 3'h1) [*5]);
  cov_done: cover property (done_o);
endmodule // ebs_chk

// ---- verification/ebs_partner.sv ----
/* Behavioural memory on the far side of the parallel bus.
   Assumes strobes and chip selects come straight from the sequencer. */
`timescale 1ns/10ps
module ebs_partner (
  input  logic        clk_i,        // System clock.
  input  logic [3:0]  cs_n_i,       // Chip selects, active low.
  input  logic        rd_n_i,       // Read strobe, active low.
  input  logic        wr_n_i,       // Write strobe, active low.
  input  logic [15:0] d_i,          // Write data from the sequencer.
  input  logic [4:0]  wait_i,       // Strobe cycles before ready goes active.
  input  logic        pol_i,        // Active level of ready.
  output logic [15:0] d_o,          // Read data toward the sequencer.
  output logic        ready_o       // Ready toward the sequencer.
);
  logic [15:0] mem [16];            // One word per chip select pattern.
  logic [4:0]  cnt = 5'h0;          // Strobe cycles seen so far.
  logic [15:0] last = 16'h0000;     // Last word driven.
  // Store writes, remember reads, and count the length of the strobe.
  always @(posedge clk_i) begin
    cnt <= (rd_n_i && wr_n_i) ? 5'h0 : cnt + 5'h1;
    if (!wr_n_i) mem[cs_n_i] <= d_i;
    if (!rd_n_i) last <= mem[cs_n_i];
  end
  // Ready stays inactive until the module has had its wait cycles.
  assign ready_o = (cnt >= wait_i) ? pol_i : !pol_i;
  // A released bus shows the inverse of the last word, never a stale copy.
  assign d_o = rd_n_i ? ~last : mem[cs_n_i];
endmodule // ebs_partner

// ---- verification/test_external_bus_cycle_phase_sequencer.sv ----
/* Self-checking testbench of the bus cycle phase sequencer.
   Assumes the sequencer, its checker and the memory model compile first. */
`timescale 1ns/10ps
module test_external_bus_cycle_phase_sequencer;
  logic clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, req_i = 1'b0;
  logic req_write_i = 1'b0, ready_i, busy_o, done_o, bus_d_oe_n_o, rd_n_o, wr_n_o, ref_clk_en_o;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, req_wdata_i = 16'h0000, rd_data_o;
  logic [15:0] bus_d_i, bus_d_o, v;
  logic [1:0] req_cs_i = 2'h0;
  logic [3:0] cs_n_o;
  logic [2:0] phase_o;
  logic [4:0] wait_r = 5'h00;       // Partner wait cycles.
  logic pol_r = 1'b1;               // Partner ready level.
  int err_total = 0, total_checks = 0, cyc = 0, len, stb, s0, oe, bsy, sel;
  ebs_sequencer u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .req_i(req_i), .req_write_i(req_write_i), .req_cs_i(req_cs_i),
    .req_wdata_i(req_wdata_i), .busy_o(busy_o), .done_o(done_o), .rd_data_o(rd_data_o),
    .ready_i(ready_i), .bus_d_i(bus_d_i), .bus_d_o(bus_d_o), .bus_d_oe_n_o(bus_d_oe_n_o),
    .cs_n_o(cs_n_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .phase_o(phase_o),
    .ref_clk_en_o(ref_clk_en_o));
  ebs_partner u_mem (.clk_i(clk_i), .cs_n_i(cs_n_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
    .d_i(bus_d_o), .wait_i(wait_r), .pol_i(pol_r), .d_o(bus_d_i), .ready_o(ready_i));
  // Clock at 100 MHz, and a ceiling on the run length so a hang still reports.
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  // Compare and count; a mismatch is reported at once.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register write and read, one strobe cycle each; read data stand one cycle.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge clk_i) reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i) {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    @(posedge clk_i) reg_rd_i <= 1'b0;
    @(negedge clk_i) d = reg_rdata_o;
  endtask
  // One bus cycle; counts periods in a phase and periods with a strobe low.
  task automatic bus(input logic [1:0] cs, input logic w, input logic [15:0] wd);
    int n;
    len = 0;
    stb = 0;
    oe = 0;
    bsy = 0;
    sel = 0;
    @(posedge clk_i) {req_i, req_cs_i, req_write_i, req_wdata_i} <= {1'b1, cs, w, wd};
    @(posedge clk_i) req_i <= 1'b0;
    for (n = 0; n < 200 && done_o !== 1'b1; n++) begin
      @(negedge clk_i);
      if (phase_o !== 3'h0) len++;
      if (rd_n_o === 1'b0 || wr_n_o === 1'b0) stb++;
      if (bus_d_oe_n_o === 1'b0) oe++;
      if (busy_o === 1'b1) bsy++;
      if (phase_o !== 3'h0 && cs_n_o === ~(4'h1 << cs)) sel++;
    end
    chk(done_o, 1'b1);
    chk(bsy, len);
    chk(sel, len);
  endtask
  // Timing words are write-only and read as zero, unmapped reads give zero,
  // the reference clock enable shows one cycle after its control bit lands.
  task automatic s_regs();
    rd(8'h00, v); chk(v, 16'h0000);
    wr(8'h01, 16'h193F); rd(8'h01, v); chk(v, 16'h0000);
    rd(8'h80, v); chk(v, 16'h0000);
    wr(8'h40, 16'h0001); @(posedge clk_i); @(negedge clk_i); chk(ref_clk_en_o, 1'b1);
    rd(8'h40, v); chk(v, 16'h0001);
    rd(8'h41, v); chk(v, 16'h0000);
  endtask
  // Shortest cycles: one setup period, one access period, empty phases skipped.
  task automatic s_min();
    bus(2'h0, 1'b1, 16'h1234); chk(len, 2); chk(stb, 1); chk(oe, 1);
    bus(2'h0, 1'b0, 16'h0000); chk(len, 2); chk(rd_data_o, 16'h1234); chk(oe, 0);
    rd(8'h42, v); chk(v, 16'h1234);
  endtask
  // Every phase but access at its maximum, first with a window change, then without.
  task automatic s_long();
    bus(2'h1, 1'b1, 16'hBEEF); chk(len, 17); chk(stb, 5); chk(oe, 12);
    bus(2'h1, 1'b0, 16'h0000); chk(len, 14); chk(rd_data_o, 16'hBEEF); chk(oe, 0);
  endtask
  // Ready handshake: both polarities synchronous, then the slower async path.
  task automatic s_ready();
    wait_r <= 5'h03;
    wr(8'h02, 16'h6020); bus(2'h2, 1'b0, 16'h0000); chk(len, stb + 2); chk(stb >= 4, 1'b1);
    s0 = stb;
    pol_r <= 1'b0;
    wr(8'h02, 16'h2000); bus(2'h2, 1'b0, 16'h0000); chk(stb, s0);
    pol_r <= 1'b1;
    wr(8'h02, 16'hE000); bus(2'h2, 1'b0, 16'h0000); chk(stb > s0, 1'b1);
    wait_r <= 5'h00;
  endtask
  // Mid-run reset: control and timing words clear, first cycle is a window change.
  task automatic s_reset();
    @(posedge clk_i) nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i); chk(ref_clk_en_o, 1'b0);
    rd(8'h40, v); chk(v, 16'h0000);
    bus(2'h1, 1'b0, 16'h0000); chk(len, 2); chk(rd_data_o, 16'hBEEF);
  endtask
  // Closing report and verdict.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    s_regs();
    s_min();
    s_long();
    s_ready();
    s_reset();
    complete_run();
  end
endmodule // test_external_bus_cycle_phase_sequencer
bind ebs_sequencer ebs_chk #(.NCS(NCS)) u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .done_o(done_o),
  .phase_o(phase_o), .cs_n_o(cs_n_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o));
